// ==== pwm_action_assertions.sv ====
/* Concurrent checks on generator 0 of the PWM output-action block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`include "pwm_action_cfg.svh"
module pwm_action_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pwm_action_pkg::reg_req_type reg_req,
    input wire logic [31:0] reg_rdata_r,
    input wire pwm_action_pkg::gen_events_type gen0_events,
    input wire logic gen0_output_a,
    input wire logic gen0_output_b
);
    import pwm_action_pkg::*;
    // ----
    // Shadow of the generator 0 registers
    // ----
    logic [11:0] fa_r;
    logic [11:0] fb_r;
    logic mode_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fa_r <= 12'h000;
            fb_r <= 12'h000;
            mode_r <= 1'b0;
        end else if (reg_req.wr) begin
            if (reg_req.addr == `GEN0_A_OFFSET) fa_r <= reg_req.wdata[11:0];
            if (reg_req.addr == `GEN0_B_OFFSET) fb_r <= reg_req.wdata[11:0];
            if (reg_req.addr == `GEN0_CTL_OFFSET) mode_r <= reg_req.wdata[1];
        end
    end
    function automatic logic act(logic [1:0] a, logic c);
        return (a == 2'h1) ? !c : (a == 2'h2) ? 1'b0 : (a == 2'h3) ? 1'b1 : c;
    endfunction : act
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence ld_only;
        !gen0_events.zero && gen0_events.load;
    endsequence
    sequence cmp_pair;
        !gen0_events.zero && !gen0_events.load && !mode_r
            && gen0_events.cmp_a_down && gen0_events.cmp_b_down;
    endsequence
    chk_zero_first: assert property (gen0_events.zero |=>
        gen0_output_a == act($past(fa_r[1:0]), $past(gen0_output_a))) else $error("zero action");
    chk_load_b_act: assert property (ld_only |=>
        gen0_output_b == act($past(fb_r[3:2]), $past(gen0_output_b))) else $error("load action");
    chk_a_cmp_wins: assert property (cmp_pair |=>
        gen0_output_a == act($past(fa_r[7:6]), $past(gen0_output_a))) else $error("A priority");
    chk_b_cmp_wins: assert property (cmp_pair |=>
        gen0_output_b == act($past(fb_r[11:10]), $past(gen0_output_b))) else $error("B priority");
    chk_up_ignored: assert property (!mode_r && (gen0_events & 6'h35) == 6'h00 |=>
        $stable(gen0_output_a) && $stable(gen0_output_b)) else $error("up event in down mode");
    chk_hold_idle: assert property (gen0_events == 6'h00 ##1 gen0_events == 6'h00 |=>
        $stable(gen0_output_b)) else $error("output moved without event");
    chk_b_readback: assert property (reg_req.rd && reg_req.addr == `GEN0_B_OFFSET |=>
        reg_rdata_r == {20'h0, $past(fb_r)}) else $error("B register read");
    chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata_r == 32'h0)
        else $error("read data without read");
endmodule : pwm_action_assertions
bind pwm_output_action_logic pwm_action_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata_r(reg_rdata_r), .gen0_events(gen0_events),
    .gen0_output_a(gen0_output_a), .gen0_output_b(gen0_output_b));

// ==== pwm_action_cfg.svh ====
/*
 * Register offsets, field positions and reset values for the PWM output-action block.
 * Assumes a byte-addressed register port; every offset is a word address times four.
 */
`ifndef PWM_ACTION_CFG_SVH
`define PWM_ACTION_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GEN0_A_OFFSET 12'h060
`define GEN1_A_OFFSET 12'h0A0
`define GEN2_A_OFFSET 12'h0E0
`define GEN0_B_OFFSET 12'h064
`define GEN1_B_OFFSET 12'h0A4
`define GEN2_B_OFFSET 12'h0E4
`define GEN0_CTL_OFFSET 12'h040
`define GEN1_CTL_OFFSET 12'h080
`define GEN2_CTL_OFFSET 12'h0C0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ZERO_LSB 0
`define LOAD_LSB 2
`define CAU_LSB 4
`define CAD_LSB 6
`define CBU_LSB 8
`define CBD_LSB 10
`define ACT_REG_WIDTH 12
`define CTL_MODE_BIT 1

// ----------------------------------------------------------------------
// Reset values and action codes
// ----------------------------------------------------------------------
`define ACT_REG_RESET 12'h000
`define CTL_RESET 1'b0
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_LOW 2'h2
`define ACT_HIGH 2'h3

`endif

// ==== pwm_action_pkg.sv ====
/*
 * Types shared by the PWM output-action block.
 * Assumes the constants header is compiled alongside.
 */
package pwm_action_pkg;

    // Counter and comparator event pulses of one generator, one cycle each.
    typedef struct packed {
        logic zero;
        logic load;
        logic cmp_a_up;
        logic cmp_a_down;
        logic cmp_b_up;
        logic cmp_b_down;
    } gen_events_type;

    typedef struct packed {
        logic [1:0] cmp_b_down_action;
        logic [1:0] cmp_b_up_action;
        logic [1:0] cmp_a_down_action;
        logic [1:0] cmp_a_up_action;
        logic [1:0] load_match_action;
        logic [1:0] zero_match_action;
    } action_fields_type;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage : pwm_action_pkg

// ==== pwm_output_action_logic.sv ====
/*
 * PWM output-action logic for three generators, each with outputs A and B.
 * Register map, byte offsets, generator n = 0..2 spaced 0x040 apart:
 *   control word (bit 1 = up/down mode) at 0x040 + n * 0x040,
 *   output A action word at 0x060 + n * 0x040,
 *   output B action word at 0x064 + n * 0x040.
 * Action words hold six two-bit fields in bits 11:0; bits 31:12 read zero.
 * Assumes the counter and comparators sit outside and deliver one-cycle event pulses
 * on mclk; register port strobes come from a master on the same clock.
 */
// Notes on behaviour
// - Two-bit actions: keep, toggle, low, high.
// - Bits 9:8 act on compare B up.
// - Bits 7:6 act on compare A down.
// - Bits 5:4 act on compare A up.
// - Bits 3:2 act on counter equals load.
// - Bits 1:0 act on counter zero.
// - All action fields reset to zero.
// - B output driven by its own register.
// - Up matches only in up/down mode.
// - Zero or load beats comparator events.
// - Output B: compare B beats compare A.
// - B registers at 0x064, 0x0A4, 0x0E4.
// - Output A: compare A beats compare B.
// - Bits 11:10 act on compare B down.
`timescale 1ns/1ps
`include "pwm_action_cfg.svh"

module pwm_output_action_logic (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pwm_action_pkg::reg_req_type reg_req,
    output logic [31:0] reg_rdata_r,
    input wire pwm_action_pkg::gen_events_type gen0_events,
    input wire pwm_action_pkg::gen_events_type gen1_events,
    input wire pwm_action_pkg::gen_events_type gen2_events,
    output logic gen0_output_a,
    output logic gen1_output_a,
    output logic gen2_output_a,
    output logic gen0_output_b,
    output logic gen1_output_b,
    output logic gen2_output_b
);
    import pwm_action_pkg::*;

    logic [11:0] act_a_r [0:2];
    logic [11:0] act_b_r [0:2];
    logic [2:0] mode_r;
    logic [31:0] rdata_nxt;
    gen_events_type ev [0:2];
    logic [2:0] out_a;
    logic [2:0] out_b;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic [2:0] sel_ctl;
    logic [2:0] wr_a_en;
    logic [2:0] wr_b_en;
    logic [2:0] wr_ctl_en;
    action_fields_type fields_a [0:2];
    action_fields_type fields_b [0:2];

    assign ev[0] = gen0_events;
    assign ev[1] = gen1_events;
    assign ev[2] = gen2_events;

    // The action words are viewed as named fields once, so every channel sees one layout.
    assign fields_a[0] = action_fields_type'(act_a_r[0]);
    assign fields_a[1] = action_fields_type'(act_a_r[1]);
    assign fields_a[2] = action_fields_type'(act_a_r[2]);
    assign fields_b[0] = action_fields_type'(act_b_r[0]);
    assign fields_b[1] = action_fields_type'(act_b_r[1]);
    assign fields_b[2] = action_fields_type'(act_b_r[2]);

    // Index 0..2 of a generator's A, B or control word; 3 means no match.
    function automatic logic [1:0] gen_index(input logic [11:0] addr, input logic [1:0] kind);
        logic [11:0] base;
        base = (kind == 2'h0) ? `GEN0_A_OFFSET :
               (kind == 2'h1) ? `GEN0_B_OFFSET : `GEN0_CTL_OFFSET;
        if (addr == base) begin
            gen_index = 2'h0;
        end else if (addr == base + 12'h040) begin
            gen_index = 2'h1;
        end else if (addr == base + 12'h080) begin
            gen_index = 2'h2;
        end else begin
            gen_index = 2'h3;
        end
    endfunction : gen_index

    // Action words occupy bits 11:0; the upper bits always read as zero.
    function automatic logic [31:0] action_word(input logic [11:0] f);
        action_word = {20'h00000, f};
    endfunction : action_word

    // The control word carries the mode bit alone; other bits read zero.
    function automatic logic [31:0] ctl_word(input logic m);
        ctl_word = 32'h0000_0000;
        ctl_word[`CTL_MODE_BIT] = m;
    endfunction : ctl_word

    // ----------------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------------
    // Writes and reads share one set of selects, so a word always reads back from
    // the same address that changes it.
    always_comb begin
        sel_a = 3'h0;
        sel_b = 3'h0;
        sel_ctl = 3'h0;
        for (int i = 0; i < 3; i++) begin
            sel_a[i] = (gen_index(reg_req.addr, 2'h0) == 2'(i));
            sel_b[i] = (gen_index(reg_req.addr, 2'h1) == 2'(i));
            sel_ctl[i] = (gen_index(reg_req.addr, 2'h2) == 2'(i));
        end
    end

    assign wr_a_en = sel_a & {3{reg_req.wr}};
    assign wr_b_en = sel_b & {3{reg_req.wr}};
    assign wr_ctl_en = sel_ctl & {3{reg_req.wr}};

    // ----------------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------------
    // One process per generator; bits 31:12 of an action word are dropped on write.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_a_r[0] <= `ACT_REG_RESET;
            act_b_r[0] <= `ACT_REG_RESET;
            mode_r[0] <= `CTL_RESET;
        end else begin
            if (wr_a_en[0]) begin
                act_a_r[0] <= reg_req.wdata[11:0];
            end
            if (wr_b_en[0]) begin
                act_b_r[0] <= reg_req.wdata[11:0];
            end
            if (wr_ctl_en[0]) begin
                mode_r[0] <= reg_req.wdata[`CTL_MODE_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_a_r[1] <= `ACT_REG_RESET;
            act_b_r[1] <= `ACT_REG_RESET;
            mode_r[1] <= `CTL_RESET;
        end else begin
            if (wr_a_en[1]) begin
                act_a_r[1] <= reg_req.wdata[11:0];
            end
            if (wr_b_en[1]) begin
                act_b_r[1] <= reg_req.wdata[11:0];
            end
            if (wr_ctl_en[1]) begin
                mode_r[1] <= reg_req.wdata[`CTL_MODE_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_a_r[2] <= `ACT_REG_RESET;
            act_b_r[2] <= `ACT_REG_RESET;
            mode_r[2] <= `CTL_RESET;
        end else begin
            if (wr_a_en[2]) begin
                act_a_r[2] <= reg_req.wdata[11:0];
            end
            if (wr_b_en[2]) begin
                act_b_r[2] <= reg_req.wdata[11:0];
            end
            if (wr_ctl_en[2]) begin
                mode_r[2] <= reg_req.wdata[`CTL_MODE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (sel_a[0]) begin
            rdata_nxt = action_word(act_a_r[0]);
        end
        if (sel_b[0]) begin
            rdata_nxt = action_word(act_b_r[0]);
        end
        if (sel_ctl[0]) begin
            rdata_nxt = ctl_word(mode_r[0]);
        end

        if (sel_a[1]) begin
            rdata_nxt = action_word(act_a_r[1]);
        end
        if (sel_b[1]) begin
            rdata_nxt = action_word(act_b_r[1]);
        end
        if (sel_ctl[1]) begin
            rdata_nxt = ctl_word(mode_r[1]);
        end

        if (sel_a[2]) begin
            rdata_nxt = action_word(act_a_r[2]);
        end
        if (sel_b[2]) begin
            rdata_nxt = action_word(act_b_r[2]);
        end
        if (sel_ctl[2]) begin
            rdata_nxt = ctl_word(mode_r[2]);
        end
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (reg_req.rd) begin
            reg_rdata_r <= rdata_nxt;
        end else begin
            reg_rdata_r <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------------
    // Output channels
    // ----------------------------------------------------------------------
    // Output A and output B of a generator share the event pulses but not the
    // action words; each channel resolves coincident events on its own, so the
    // two pins may take different actions in the same cycle.
    // generator 0 output A
    pwm_output_channel u_gen0_a (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[0]),
        .actions(fields_a[0]),
        .up_down_mode(mode_r[0]),
        .b_wins(1'b0),
        .out_r(out_a[0])
    );

    pwm_output_channel u_gen0_b (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[0]),
        .actions(fields_b[0]),
        .up_down_mode(mode_r[0]),
        .b_wins(1'b1),
        .out_r(out_b[0])
    );

    pwm_output_channel u_gen1_a (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[1]),
        .actions(fields_a[1]),
        .up_down_mode(mode_r[1]),
        .b_wins(1'b0),
        .out_r(out_a[1])
    );

    pwm_output_channel u_gen1_b (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[1]),
        .actions(fields_b[1]),
        .up_down_mode(mode_r[1]),
        .b_wins(1'b1),
        .out_r(out_b[1])
    );

    pwm_output_channel u_gen2_a (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[2]),
        .actions(fields_a[2]),
        .up_down_mode(mode_r[2]),
        .b_wins(1'b0),
        .out_r(out_a[2])
    );

    pwm_output_channel u_gen2_b (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .events(ev[2]),
        .actions(fields_b[2]),
        .up_down_mode(mode_r[2]),
        .b_wins(1'b1),
        .out_r(out_b[2])
    );

    // Channel outputs are flip-flops already; these are plain wires to the pins.
    assign gen0_output_a = out_a[0];
    assign gen1_output_a = out_a[1];
    assign gen2_output_a = out_a[2];
    assign gen0_output_b = out_b[0];
    assign gen1_output_b = out_b[1];
    assign gen2_output_b = out_b[2];

endmodule : pwm_output_action_logic

// ==== pwm_output_action_logic_tb_top.sv ====
/* Self-checking bench for the PWM output-action block.
   Assumes reads answer one cycle late and events act at the edge that ends them. */
`timescale 1ns/1ps
module pwm_output_action_logic_tb_top;
    import pwm_action_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_type req = '0;
    logic [31:0] rdata;
    gen_events_type ev [3] = '{default: '0};
    logic oa [3];
    logic ob [3];
    logic xa [3] = '{default: 1'b0};
    logic xb [3] = '{default: 1'b0};
    logic [11:0] fa [3] = '{default: 12'h000};
    logic [11:0] fb [3] = '{default: 12'h000};
    logic md [3] = '{default: 1'b0};
    logic [31:0] expq [$];
    logic rd_q = 1'b0;
    logic [5:0] outq [$];
    logic [5:0] xo;
    logic ev_live = 1'b0;
    logic ev_q = 1'b0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    pwm_output_action_logic uut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(req),
        .reg_rdata_r(rdata), .gen0_events(ev[0]), .gen1_events(ev[1]), .gen2_events(ev[2]),
        .gen0_output_a(oa[0]), .gen1_output_a(oa[1]), .gen2_output_a(oa[2]),
        .gen0_output_b(ob[0]), .gen1_output_b(ob[1]), .gen2_output_b(ob[2]));
    always #20 mclk = ~mclk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic check(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rd_q <= req.rd;
        ev_q <= ev_live;
        if (rd_q && expq.size() > 0) check(rdata, expq.pop_front());
        if (ev_q && outq.size() > 0) begin
            xo = outq.pop_front();
            for (int g = 0; g < 3; g++) begin
                check({31'h0, oa[g]}, {31'h0, xo[g]});
                check({31'h0, ob[g]}, {31'h0, xo[g + 3]});
            end
        end
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] e);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        expq.push_back(e);
        @(posedge mclk);
        req.rd <= 1'b0;
    endtask : rd
    // ----
    // Reference model: zero, load, then own comparator before the other one
    // ----
    function automatic logic nxt(logic [11:0] f, logic [5:0] e, logic m, logic c, logic bw);
        logic [1:0] a;
        logic ca;
        logic cb;
        ca = (m & e[3]) | e[2];
        cb = (m & e[1]) | e[0];
        if (e[5]) a = f[1:0];
        else if (e[4]) a = f[3:2];
        else if (ca && !(bw && cb)) a = (m & e[3]) ? f[5:4] : f[7:6];
        else if (cb) a = (m & e[1]) ? f[9:8] : f[11:10];
        else a = 2'h0;
        return (a == 2'h1) ? !c : (a == 2'h2) ? 1'b0 : (a == 2'h3) ? 1'b1 : c;
    endfunction : nxt
    task automatic prog(int g);
        fa[g] = 12'($urandom);
        fb[g] = 12'($urandom);
        md[g] = 1'($urandom);
        wr(12'h060 + 12'h040 * g[11:0], {20'($urandom), fa[g]});
        wr(12'h064 + 12'h040 * g[11:0], {20'($urandom), fb[g]});
        wr(12'h040 + 12'h040 * g[11:0], {30'h0, md[g], 1'b0});
    endtask : prog
    task automatic chk_regs();
        for (int g = 0; g < 3; g++) begin
            rd(12'h060 + 12'h040 * g[11:0], {20'h0, fa[g]});
            rd(12'h064 + 12'h040 * g[11:0], {20'h0, fb[g]});
            rd(12'h040 + 12'h040 * g[11:0], {30'h0, md[g], 1'b0});
        end
    endtask : chk_regs
    task automatic fire();
        logic [5:0] e [3];
        for (int g = 0; g < 3; g++) begin
            e[g] = 6'($urandom);
            if ($urandom % 2) e[g] = e[g] & 6'($urandom) & 6'($urandom);
            xa[g] = nxt(fa[g], e[g], md[g], xa[g], 1'b0);
            xb[g] = nxt(fb[g], e[g], md[g], xb[g], 1'b1);
        end
        outq.push_back({xb[2], xb[1], xb[0], xa[2], xa[1], xa[0]});
        @(posedge mclk);
        for (int g = 0; g < 3; g++) ev[g] <= e[g];
        ev_live <= 1'b1;
        @(posedge mclk);
        for (int g = 0; g < 3; g++) ev[g] <= '0;
        ev_live <= 1'b0;
    endtask : fire
    initial begin
        void'($urandom(79));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_regs();
        wr(12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h0);
        $display("test reset and map done");
        repeat (50) begin
            for (int g = 0; g < 3; g++) prog(g);
            repeat (6) fire();
        end
        chk_regs();
        $display("test event actions done");
        // mid-run reset clears registers and outputs
        @(posedge mclk) sys_rst <= 1'b1;
        @(posedge mclk) sys_rst <= 1'b0;
        fa = '{default: 12'h000};
        fb = '{default: 12'h000};
        md = '{default: 1'b0};
        xa = '{default: 1'b0};
        xb = '{default: 1'b0};
        repeat (4) fire();
        chk_regs();
        $display("test second reset done");
        close_out();
    end
endmodule : pwm_output_action_logic_tb_top

// ==== pwm_output_channel.sv ====
/*
 * One PWM output: applies the winning event action to its output flip-flop.
 * Assumes event pulses are synchronous to mclk and one cycle long.
 */
`timescale 1ns/1ps
`include "pwm_action_cfg.svh"

module pwm_output_channel (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pwm_action_pkg::gen_events_type events,
    input wire pwm_action_pkg::action_fields_type actions,
    input wire logic up_down_mode,
    input wire logic b_wins,
    output logic out_r
);
    import pwm_action_pkg::*;

    logic [1:0] act_sel;
    logic a_up;
    logic b_up;
    logic a_ev;
    logic b_ev;
    logic out_nxt;

    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        case (act)
            `ACT_TOGGLE: apply_action = ~cur;
            `ACT_LOW: apply_action = 1'b0;
            `ACT_HIGH: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction : apply_action

    // ----------------------------------------------------------------------
    // Event priority
    // ----------------------------------------------------------------------
    always_comb begin
        a_up = events.cmp_a_up & up_down_mode;
        b_up = events.cmp_b_up & up_down_mode;
        a_ev = a_up | events.cmp_a_down;
        b_ev = b_up | events.cmp_b_down;
        act_sel = `ACT_NONE;
        if (events.zero) begin
            act_sel = actions.zero_match_action;
        end else if (events.load) begin
            act_sel = actions.load_match_action;
        end else if (a_ev && (!b_wins || !b_ev)) begin
            act_sel = a_up ? actions.cmp_a_up_action : actions.cmp_a_down_action;
        end else if (b_ev) begin
            act_sel = b_up ? actions.cmp_b_up_action : actions.cmp_b_down_action;
        end
        out_nxt = apply_action(act_sel, out_r);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

endmodule : pwm_output_channel
